// File: rtl/scr_regs.sv
/*
 * System control register pair of the core's system coprocessor.
 * Assumes the core issues single-cycle register transfers on the
 * request port, synchronous to sys_clk_in.
 */
// Function
// - selector 0 control, 1 auxiliary
// - bit 13 relocates vectors high
// - vectors translated when translation enabled
// - reset clears; bits 6:3 read one
// - bit 12 enables instruction cache
// - bit 11 enables branch target buffer
// - bits 9,8 select ROM/system protection
// - bit 7 selects big endian
// - bit 2 enables data cache
// - bit 1 enables alignment faults
// - aux field sets minicache policy
// - policy codes: WB-RA, WB-RWA, WT-RA
// - aux bit 0 disables coalescing
`timescale 1ns/1ps
`default_nettype none

module scr_regs (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire scr_pkg::scr_req_t req_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    output var scr_pkg::scr_ctl_t ctl_out
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic hit_ctrl;
    logic hit_aux;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_view;
    logic [31:0] aux_val;
    logic [31:0] rdata_q;
    logic rvalid_q;

    // Selector decides which register is addressed
    assign hit_ctrl = req_in.valid && (req_in.sel == scr_pkg::SEL_CTRL);
    assign hit_aux = req_in.valid && (req_in.sel == scr_pkg::SEL_AUX);

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Only writable bits are stored; reserved ones ignore writes
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            ctrl_q <= scr_pkg::CTL_RESET;
        else if (ce_in && hit_ctrl && req_in.write)
            ctrl_q <= req_in.wdata & scr_pkg::CTL_WMASK;
    end

    // Bits 6:3 always read as one
    assign ctrl_view = ctrl_q | scr_pkg::CTL_ONES;

    // Auxiliary register
    scr_aux u_aux (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .wr_in(hit_aux && req_in.write),
        .wdata_in(req_in.wdata),
        .value_out(aux_val)
    );

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Read data registered, one cycle after the request
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end
        else if (ce_in)
        begin
            rvalid_q <= req_in.valid && !req_in.write;
            if (req_in.valid && !req_in.write)
            begin
                if (hit_ctrl)
                    rdata_q <= ctrl_view;
                else if (hit_aux)
                    rdata_q <= aux_val;
                else
                    rdata_q <= 32'h0000_0000; // Unknown selector
            end
        end
    end

    assign rdata_out = rdata_q;
    assign rvalid_out = rvalid_q;

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    // Enables and selects taken straight from stored bits
    always_comb
    begin
        ctl_out.xlate_en = ctrl_q[scr_pkg::CTL_XLATE];
        ctl_out.align_en = ctrl_q[scr_pkg::CTL_ALIGN];
        ctl_out.dcache_en = ctrl_q[scr_pkg::CTL_DCACHE];
        ctl_out.big_endian = ctrl_q[scr_pkg::CTL_BIGEND];
        ctl_out.sys_prot = ctrl_q[scr_pkg::CTL_SYSPROT];
        ctl_out.rom_prot = ctrl_q[scr_pkg::CTL_ROMPROT];
        ctl_out.btb_en = ctrl_q[scr_pkg::CTL_BTB];
        ctl_out.icache_en = ctrl_q[scr_pkg::CTL_ICACHE];
        ctl_out.vec_high = ctrl_q[scr_pkg::CTL_VECHI];
        ctl_out.vec_base = ctrl_q[scr_pkg::CTL_VECHI] ? scr_pkg::VEC_HIGH
                                                      : scr_pkg::VEC_LOW;
        // Vector fetches use normal translation when enabled
        ctl_out.vec_translate = ctrl_q[scr_pkg::CTL_XLATE];
        ctl_out.minicache_policy = aux_val[scr_pkg::AUX_POL_LO +: 2];
        ctl_out.mini_write_through = 1'b0;
        ctl_out.mini_write_alloc = 1'b0;
        unique case (aux_val[scr_pkg::AUX_POL_LO +: 2])
            scr_pkg::POL_WB_RA: ctl_out.mini_write_alloc = 1'b0;
            scr_pkg::POL_WB_RWA: ctl_out.mini_write_alloc = 1'b1;
            scr_pkg::POL_WT_RA: ctl_out.mini_write_through = 1'b1;
            scr_pkg::POL_UNPRED: ctl_out.mini_write_through = 1'b1; // Unpredictable
        endcase
        ctl_out.coalesce_off = aux_val[scr_pkg::AUX_NOCOAL];
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_ones_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && !req_in.write |=> rdata_out[6:3] == 4'hF && rvalid_out)
        else $error("bits 6:3 not one");
    chk_reset_clear: assert property (@(posedge sys_clk_in)
        rst_in |=> ctrl_q == 32'h0000_0000 && aux_val == 32'h0000_0000)
        else $error("reset did not clear");
    chk_ctrl_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=>
            ctl_out.icache_en == $past(req_in.wdata[12]) &&
            ctl_out.btb_en == $past(req_in.wdata[11]))
        else $error("control write not applied");
    chk_vec_base: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ctl_out.vec_base == (ctrl_q[13] ? 32'hFFFF_0000 : 32'h0000_0000))
        else $error("vector base wrong");
    chk_aux_isolate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_aux && req_in.write |=> $stable(ctrl_q))
        else $error("aux write hit control");
    chk_freeze: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !ce_in |=> $stable(ctrl_q) && $stable(rdata_out))
        else $error("state moved while frozen");
    chk_coalesce: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_aux && req_in.write |=> ctl_out.coalesce_off == $past(req_in.wdata[0]))
        else $error("coalesce bit wrong");
    chk_policy_wt: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ctl_out.minicache_policy == 2'h2 |-> ctl_out.mini_write_through && !ctl_out.mini_write_alloc)
        else $error("write-through decode wrong");
    chk_field_map: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ctl_out.big_endian == rdata_q[7] || !$past(hit_ctrl && !req_in.write && ce_in) ||
        $past(hit_ctrl && req_in.write && ce_in))
        else $error("endian bit mismatch");

    // Remaining control fields follow the written data
    chk_prot_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=>
            ctl_out.rom_prot == $past(req_in.wdata[9]) &&
            ctl_out.sys_prot == $past(req_in.wdata[8]))
        else $error("protection selects not applied");
    chk_endian_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=> ctl_out.big_endian == $past(req_in.wdata[7]))
        else $error("endian select not applied");
    chk_dcache_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=> ctl_out.dcache_en == $past(req_in.wdata[2]))
        else $error("data cache enable not applied");
    chk_align_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=> ctl_out.align_en == $past(req_in.wdata[1]))
        else $error("alignment enable not applied");
    chk_xlate_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=> ctl_out.xlate_en == $past(req_in.wdata[0]))
        else $error("translation enable not applied");
    chk_vec_xlate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && req_in.write |=> ctl_out.vec_translate == $past(req_in.wdata[0]))
        else $error("vector translation wrong");
    chk_ctrl_reserved: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (ctrl_q & ~scr_pkg::CTL_WMASK) == 32'h0000_0000)
        else $error("control reserved bits set");

    // Read data and selector decode
    chk_ctrl_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_ctrl && !req_in.write |=>
            rdata_out == ($past(ctrl_q) | scr_pkg::CTL_ONES))
        else $error("control read data wrong");
    chk_aux_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_aux && !req_in.write |=> rdata_out == $past(aux_val))
        else $error("aux read data wrong");
    chk_unmapped_wr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && req_in.valid && req_in.write && !hit_ctrl && !hit_aux |=>
            $stable(ctrl_q) && $stable(aux_val))
        else $error("unmapped write changed state");
    chk_rvalid_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && !(req_in.valid && !req_in.write) |=> !rvalid_out)
        else $error("read answer without read");

    // Minicache policy decode
    chk_policy_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hit_aux && req_in.write |=>
            ctl_out.minicache_policy == $past(req_in.wdata[5:4]))
        else $error("policy field not applied");
    chk_policy_wb: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !ctl_out.minicache_policy[1] |-> !ctl_out.mini_write_through &&
            ctl_out.mini_write_alloc == ctl_out.minicache_policy[0])
        else $error("write-back decode wrong");

    cov_ctrl_write: cover property (@(posedge sys_clk_in) ce_in && hit_ctrl && req_in.write);
    cov_aux_read: cover property (@(posedge sys_clk_in) ce_in && hit_aux && !req_in.write);
    cov_vec_high: cover property (@(posedge sys_clk_in) ctl_out.vec_high && ctl_out.xlate_en);
    cov_unmapped: cover property (@(posedge sys_clk_in)
        ce_in && req_in.valid && !hit_ctrl && !hit_aux);
    cov_policy_rwa: cover property (@(posedge sys_clk_in) ctl_out.mini_write_alloc);

endmodule

`default_nettype wire

// File: rtl/scr_pkg.sv
/*
 * Package for the system control register pair: field positions,
 * reset values, selector codes and carrier structs.
 * Assumes a single core clock domain and a synchronous reset.
 */
package scr_pkg;

    // ****************************************************************
    // Selector codes
    // ****************************************************************
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_AUX = 3'h1;

    // ****************************************************************
    // Control register field positions
    // ****************************************************************
    localparam int CTL_XLATE = 0;
    localparam int CTL_ALIGN = 1;
    localparam int CTL_DCACHE = 2;
    localparam int CTL_BIGEND = 7;
    localparam int CTL_SYSPROT = 8;
    localparam int CTL_ROMPROT = 9;
    localparam int CTL_BTB = 11;
    localparam int CTL_ICACHE = 12;
    localparam int CTL_VECHI = 13;
    localparam logic [31:0] CTL_WMASK = 32'h0000_3B87;
    localparam logic [31:0] CTL_ONES = 32'h0000_0078;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;

    // ****************************************************************
    // Auxiliary register field positions
    // ****************************************************************
    localparam int AUX_NOCOAL = 0;
    localparam int AUX_PGATTR = 1;
    localparam int AUX_POL_LO = 4;
    localparam logic [31:0] AUX_WMASK = 32'h0000_0033;
    localparam logic [31:0] AUX_RESET = 32'h0000_0000;

    // ****************************************************************
    // Vector bases and policy codes
    // ****************************************************************
    localparam logic [31:0] VEC_LOW = 32'h0000_0000;
    localparam logic [31:0] VEC_HIGH = 32'hFFFF_0000;
    localparam logic [1:0] POL_WB_RA = 2'h0;
    localparam logic [1:0] POL_WB_RWA = 2'h1;
    localparam logic [1:0] POL_WT_RA = 2'h2;
    localparam logic [1:0] POL_UNPRED = 2'h3;

    // Core register transfer request
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] sel;
        logic [31:0] wdata;
    } scr_req_t;

    // Control outputs towards the core
    typedef struct packed {
        logic xlate_en;
        logic align_en;
        logic dcache_en;
        logic big_endian;
        logic sys_prot;
        logic rom_prot;
        logic btb_en;
        logic icache_en;
        logic vec_high;
        logic [31:0] vec_base;
        logic vec_translate;
        logic [1:0] minicache_policy;
        logic mini_write_through;
        logic mini_write_alloc;
        logic coalesce_off;
    } scr_ctl_t;

endpackage

// File: rtl/scr_aux.sv
/*
 * Auxiliary control register: minicache policy and coalescing disable.
 * Assumes writes arrive already decoded from the transfer port.
 */
`timescale 1ns/1ps
`default_nettype none

module scr_aux (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] value_out
);

    logic [31:0] aux_q;

    // Writable bits only; reserved bits stay zero
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            aux_q <= scr_pkg::AUX_RESET;
        else if (ce_in && wr_in)
            aux_q <= wdata_in & scr_pkg::AUX_WMASK;
    end

    assign value_out = aux_q;

    chk_aux_reserved: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (aux_q & ~scr_pkg::AUX_WMASK) == 32'h0000_0000)
        else $error("aux reserved bits set");
    chk_aux_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ce_in && wr_in |=> aux_q == ($past(wdata_in) & scr_pkg::AUX_WMASK))
        else $error("aux write not stored");

endmodule

`default_nettype wire

// File: testbench/scr_core_model.sv
/*
 * Core side model: issues register transfers to the control pair.
 * Assumes the caller sits in the same clock domain as the block.
 */
`timescale 1ns/1ps
`default_nettype none

module scr_core_model (
    input wire logic sys_clk_in,
    input wire logic [31:0] rdata_in,
    input wire logic rvalid_in,
    output var scr_pkg::scr_req_t req_out
);
    // ************************************************************
    // Transfer task
    // ************************************************************
    logic [31:0] rd_q;
    logic ok_q;
    initial req_out = '0;
    // One request, released bus shows inverted data
    task automatic xfer(input logic w, input logic [2:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        req_out <= '{1'b1, w, s, d};
        @(posedge sys_clk_in);
        req_out <= '{1'b0, ~w, ~s, ~d};
        #1;
        while (!w && rvalid_in !== 1'b1 && n < 4)
        begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        ok_q = w || rvalid_in === 1'b1;
        rd_q = rdata_in;
    endtask
endmodule

`default_nettype wire

// File: testbench/tb.sv
/*
 * Self-checking bench for the control register pair.
 * Assumes the core model drives all transfers.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct packed {logic [2:0] s; logic [31:0] d; logic [31:0] q;} scr_row_t;
    logic sys_clk_in;
    logic rst_in;
    logic ce_in;
    scr_pkg::scr_req_t req;
    scr_pkg::scr_ctl_t ctl;
    logic [31:0] rdata;
    logic rvalid;
    int err_total;
    int compares;
    int bit_pos[9] = '{0, 1, 2, 7, 8, 9, 11, 12, 13};
    // Policy first, then control, then aux, unmapped selectors last
    scr_row_t rows[8] = '{
        '{3'h1, 32'h0000_0010, 32'h0000_0010}, '{3'h0, 32'hFFFF_FFFF, 32'h0000_3BFF},
        '{3'h0, 32'h0000_0000, 32'h0000_0078}, '{3'h0, 32'h0000_2000, 32'h0000_2078},
        '{3'h1, 32'hFFFF_FFFF, 32'h0000_0033}, '{3'h1, 32'h0000_0000, 32'h0000_0000},
        '{3'h2, 32'hFFFF_FFFF, 32'h0000_0000}, '{3'h7, 32'hFFFF_FFFF, 32'h0000_0000}};

    scr_regs DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
        .rdata_out(rdata), .rvalid_out(rvalid), .ctl_out(ctl));
    scr_core_model core (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .req_out(req));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic summarize();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Read with bounded answer wait
    task automatic rd_chk(input string nm, input logic [2:0] s, input logic [31:0] e);
        core.xfer(1'b0, s, 32'h0);
        if (core.ok_q !== 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED %s exp rvalid got timeout", nm);
            summarize();
        end
        else
            chk(nm, 64'(e), 64'(core.rd_q));
    endtask

    // Clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        err_total = 0;
        compares = 0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk("ctl reset", 64'h0, 64'(ctl));
        rd_chk("ctl rst", 3'h0, 32'h0000_0078);
        rd_chk("aux rst", 3'h1, 32'h0000_0000);
        // Table rows; policy programmed before caching starts
        foreach (rows[i])
        begin
            core.xfer(1'b1, rows[i].s, rows[i].d);
            rd_chk("row", rows[i].s, rows[i].q);
        end
        // One control bit at a time
        foreach (bit_pos[i])
        begin
            core.xfer(1'b1, 3'h0, 32'h1 << bit_pos[i]);
            chk("ctl field", 64'h1 << i, 64'({ctl.vec_high, ctl.icache_en, ctl.btb_en,
                ctl.rom_prot, ctl.sys_prot, ctl.big_endian, ctl.dcache_en, ctl.align_en,
                ctl.xlate_en}));
        end
        chk("vec base", 64'hFFFF_0000, 64'(ctl.vec_base));
        core.xfer(1'b1, 3'h0, 32'h0000_0001);
        chk("vec xlate", 64'h1, 64'({ctl.vec_base, ctl.vec_translate}));
        // Every policy code; real cache would be cleaned between changes
        for (int p = 0; p < 4; p++)
        begin
            core.xfer(1'b1, 3'h1, 32'(p) << 4 | 32'(p & 1));
            chk("policy", 64'({2'(p), p[1], p[0]}), 64'({ctl.minicache_policy,
                ctl.mini_write_through, ctl.coalesce_off}));
            if (p < 3)
                chk("alloc", 64'(p == 1), 64'(ctl.mini_write_alloc));
        end
        // Clock enable low freezes the write
        @(posedge sys_clk_in);
        ce_in <= 1'b0;
        core.xfer(1'b1, 3'h0, 32'h0000_3BFF);
        @(posedge sys_clk_in);
        ce_in <= 1'b1;
        rd_chk("ce frozen", 3'h0, 32'h0000_0079);
        // Reset in mid-run
        core.xfer(1'b1, 3'h0, 32'hFFFF_FFFF);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd_chk("ctl rerst", 3'h0, 32'h0000_0078);
        rd_chk("aux rerst", 3'h1, 32'h0000_0000);
        summarize();
    end
endmodule

`default_nettype wire
